// ### rtl/timer8_pkg.sv
// Package for the 8-bit timer with waveform generator.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package timer8_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CONTROL_A = 8'h00;
   localparam logic [7:0] OFS_COUNTER = 8'h04;
   localparam logic [7:0] OFS_COMPARE = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_PIN_CFG = 8'h10;

   // Field positions.
   localparam int BIT_FORCE = 7;
   localparam int BIT_FLAG_CMP = 1;
   localparam int BIT_FLAG_OVF = 0;
   localparam int BIT_PIN_DIR = 0;
   localparam int BIT_PORT_DATA = 1;

   // Reset values and counter limits.
   localparam logic [7:0] CONTROL_A_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;

   // Prescaler width and tap widths (divide by 8, 64, 256, 1024).
   localparam int PRESC_W = 10;
   localparam int TAP_DIV8 = 3;
   localparam int TAP_DIV64 = 6;
   localparam int TAP_DIV256 = 8;
   localparam int TAP_DIV1024 = 10;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_PHASE = 2'b01,
      MODE_CTC = 2'b10,
      MODE_FAST = 2'b11
   } wave_mode_t;

   typedef enum logic [2:0] {
      CS_STOP = 3'b000,
      CS_DIV1 = 3'b001,
      CS_DIV8 = 3'b010,
      CS_DIV64 = 3'b011,
      CS_DIV256 = 3'b100,
      CS_DIV1024 = 3'b101,
      CS_EXT_FALL = 3'b110,
      CS_EXT_RISE = 3'b111
   } clock_select_t;

   // Control register in its bit order, 7 down to 0.
   typedef struct packed {
      logic force_compare_strobe;
      logic waveform_mode_low;
      logic [1:0] output_action;
      logic waveform_mode_high;
      logic [2:0] clock_select;
   } timer_control_a_t;

   // Whole state of the main timer module.
   typedef struct packed {
      timer_control_a_t ctrl;
      logic [7:0] counter_value;
      logic [7:0] compare_buf;
      logic [7:0] compare_act;
      logic dir_down;
      logic block_match;
      logic compare_output;
      logic overflow_flag;
      logic compare_match_flag;
      logic pin_dir;
      logic port_data;
      logic ack;
      logic [31:0] rdat;
   } timer_state_t;

   // Whole state of the tick source.
   typedef struct packed {
      logic [PRESC_W-1:0] presc;
      logic sync1;
      logic sync2;
      logic prev;
   } tick_state_t;

endpackage

// ### rtl/timer8_tick_source.sv
// Timer tick source: free-running prescaler and external count pin edge detector.
// Assumes the count pin is asynchronous to the core clock.
`timescale 1ns/1ns
module timer8_tick_source
   import timer8_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_clock_select,
   input wire logic i_external_count_pin,
   output logic o_timer_tick
);

   tick_state_t s_q;
   tick_state_t s_d;
   logic ext_rise;
   logic ext_fall;

   // The pin passes two flops; only the second one feeds the edge detector.
   always_comb begin
      s_d = s_q;
      s_d.presc = s_q.presc + 1'b1;
      s_d.sync1 = i_external_count_pin;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
   end

   assign ext_rise = s_q.sync2 & ~s_q.prev;
   assign ext_fall = ~s_q.sync2 & s_q.prev;

   // Tick is a one-cycle enable; the prescaler runs free so the first tick may come early.
   always_comb begin
      case (clock_select_t'(i_clock_select))
         CS_STOP: o_timer_tick = 1'b0;
         CS_DIV1: o_timer_tick = 1'b1;
         CS_DIV8: o_timer_tick = &s_q.presc[TAP_DIV8-1:0];
         CS_DIV64: o_timer_tick = &s_q.presc[TAP_DIV64-1:0];
         CS_DIV256: o_timer_tick = &s_q.presc[TAP_DIV256-1:0];
         CS_DIV1024: o_timer_tick = &s_q.presc[TAP_DIV1024-1:0];
         CS_EXT_FALL: o_timer_tick = ext_fall;
         CS_EXT_RISE: o_timer_tick = ext_rise;
         default: o_timer_tick = 1'b0;
      endcase
   end

   // State register.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // timer8_tick_source

// ### rtl/timer8_waveform_generator.sv
// 8-bit timer/counter with waveform generator and one compare output pin.
// Assumes a classic Wishbone master on the core clock and an asynchronous count pin.
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns

// Functional notes
// - Fast PWM with action 1 toggles output on each match, compare stays buffered.
// - Phase correct mode counts up to MAX then down to BOTTOM, eight bits.
// - Phase correct does not hold MAX; the tick at MAX already decrements.
// - Phase correct sets overflow flag when counter reaches BOTTOM.
// - Phase correct action 2 clears on up match, sets on down; 3 reverses.
// - Phase correct action 2 with compare at BOTTOM gives constant low, at MAX constant high; 3 reverses.
// - Phase correct output corrects at BOTTOM after missed match or MAX change.
// - Compare at MAX keeps output symmetric around BOTTOM in phase correct.
// - Fully synchronous; the tick is only a clock enable.
// - Force strobe in non-PWM mode applies current output action at once.
// - Forced compare sets no flag and never clears the counter.
// - Force strobe is write-only and reads as zero.
// - Mode decode: normal, phase correct, clear-on-compare, fast PWM, with TOP.
// - Nonzero output action overrides port; driver enabled by direction bit.
// - Non-PWM actions: disconnected, toggle, clear, set on match.
// - Fast PWM action 2 clears on match, sets at BOTTOM; 3 reverses.
// - PWM with compare at TOP and high action bit ignores match, acts at TOP.
// - Clock select: stop, undivided, 8, 64, 256, 1024, pin fall, pin rise.
// - External pin clocks the counter even when driven as output.
// - A counter write suppresses the compare match on the next tick.
// - Flags clear by interrupt vector acknowledge or by writing one.
// - Fast PWM counts to MAX then clears on the following tick.
module timer8_waveform_generator
   import timer8_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_overflow_vec_ack,
   input wire logic i_compare_vec_ack,
   input wire logic i_external_count_pin,
   output logic o_wave_pin_o,
   output logic o_wave_pin_oe,
   output logic o_compare_output,
   output logic o_overflow_flag,
   output logic o_compare_match_flag
);

   timer_state_t s_q;
   timer_state_t s_d;
   logic timer_tick;
   wave_mode_t mode;
   logic wb_req;
   logic wb_wr;
   logic wr_ctrl;
   logic wr_counter;
   logic wr_compare;
   logic wr_flags;
   logic wr_pin;
   logic match;
   logic ignore_match;
   logic at_max;
   logic at_bottom;
   logic up_level;
   timer_control_a_t wr_ctrl_val;

   // True for both PWM modes, where compare is double buffered.
   function automatic logic is_pwm(input wave_mode_t m);
      is_pwm = (m == MODE_PHASE) || (m == MODE_FAST);
   endfunction

   // Non-PWM output action applied to the present output level.
   function automatic logic nonpwm_action(input logic [1:0] act, input logic cur);
      case (act)
         2'b01: nonpwm_action = ~cur;
         2'b10: nonpwm_action = 1'b0;
         2'b11: nonpwm_action = 1'b1;
         default: nonpwm_action = cur;
      endcase
   endfunction

   // Tick source; the pin counts regardless of the pin direction bit.
   timer8_tick_source u_tick (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_clock_select(s_q.ctrl.clock_select),
      .i_external_count_pin(i_external_count_pin),
      .o_timer_tick(timer_tick)
   );

   // Bus decode; a write lands only on the edge where ack is high.
   assign wb_req = i_wb_cyc & i_wb_stb;
   assign wb_wr = wb_req & i_wb_we & s_q.ack & i_wb_sel[0];
   assign wr_ctrl = wb_wr && (i_wb_adr == OFS_CONTROL_A);
   assign wr_counter = wb_wr && (i_wb_adr == OFS_COUNTER);
   assign wr_compare = wb_wr && (i_wb_adr == OFS_COMPARE);
   assign wr_flags = wb_wr && (i_wb_adr == OFS_FLAGS);
   assign wr_pin = wb_wr && (i_wb_adr == OFS_PIN_CFG);
   assign wr_ctrl_val = timer_control_a_t'(i_wb_dat[7:0]);

   // Mode and compare decode.
   assign mode = wave_mode_t'({s_q.ctrl.waveform_mode_high, s_q.ctrl.waveform_mode_low});
   assign match = timer_tick & ~s_q.block_match & (s_q.counter_value == s_q.compare_act);
   assign ignore_match = is_pwm(mode) & s_q.ctrl.output_action[1]
      & (s_q.compare_act == COUNT_MAX);
   assign at_max = (s_q.counter_value == COUNT_MAX);
   assign at_bottom = (s_q.counter_value == COUNT_BOTTOM);
   // Level that an up-counting match gives in the PWM modes; down match is its inverse.
   assign up_level = s_q.ctrl.output_action[0];

   // Next-state logic: counter, compare, output, flags, then bus effects on top.
   always_comb begin
      s_d = s_q;
      s_d.ack = wb_req & ~s_q.ack;
      s_d.rdat = '0;

      if (timer_tick) begin
         s_d.block_match = 1'b0;
         case (mode)
            MODE_NORMAL: begin
               s_d.counter_value = s_q.counter_value + 8'h01;
               if (at_max) begin
                  s_d.overflow_flag = 1'b1;
               end
            end
            MODE_CTC: begin
               // Only a true match clears; a forced compare never gets here.
               s_d.counter_value = match ? COUNT_BOTTOM : s_q.counter_value + 8'h01;
               if (at_max) begin
                  s_d.overflow_flag = 1'b1;
               end
            end
            MODE_FAST: begin
               // Wraps from MAX to BOTTOM; the buffered compare loads at BOTTOM.
               s_d.counter_value = s_q.counter_value + 8'h01;
               if (at_max) begin
                  s_d.overflow_flag = 1'b1;
                  s_d.compare_act = s_q.compare_buf;
               end
            end
            MODE_PHASE: begin
               if (!s_q.dir_down) begin
                  if (at_max) begin
                     s_d.dir_down = 1'b1;
                     s_d.counter_value = s_q.counter_value - 8'h01;
                     s_d.compare_act = s_q.compare_buf;
                  end else begin
                     s_d.counter_value = s_q.counter_value + 8'h01;
                  end
               end else if (at_bottom) begin
                  s_d.dir_down = 1'b0;
                  s_d.overflow_flag = 1'b1;
                  s_d.counter_value = s_q.counter_value + 8'h01;
               end else begin
                  s_d.counter_value = s_q.counter_value - 8'h01;
               end
            end
            default: begin
               s_d.counter_value = s_q.counter_value + 8'h01;
            end
         endcase

         if (match) begin
            s_d.compare_match_flag = 1'b1;
         end

         // Waveform output per mode.
         if (!is_pwm(mode)) begin
            if (match) begin
               s_d.compare_output = nonpwm_action(s_q.ctrl.output_action,
                  s_q.compare_output);
            end
         end else if (mode == MODE_FAST) begin
            if (s_q.ctrl.output_action == 2'b01) begin
               if (match) begin
                  s_d.compare_output = ~s_q.compare_output;
               end
            end else if (s_q.ctrl.output_action[1]) begin
               if (match && !ignore_match) begin
                  s_d.compare_output = up_level;
               end
               // Action at TOP also covers the ignored match with compare at MAX.
               if (at_max) begin
                  s_d.compare_output = ~up_level;
               end
            end
         end else if (s_q.ctrl.output_action[1]) begin
            if (s_q.dir_down && at_bottom) begin
               // Re-align at BOTTOM so a missed up match or a left MAX stays symmetric.
               s_d.compare_output = (s_q.compare_act == COUNT_BOTTOM) ? up_level
                  : ~up_level;
            end else if (at_max && ignore_match) begin
               s_d.compare_output = ~up_level;
            end else if (match && !ignore_match) begin
               s_d.compare_output = s_q.dir_down ? ~up_level : up_level;
            end
         end
      end

      // Control register; force acts only outside PWM and is never stored.
      if (wr_ctrl) begin
         s_d.ctrl = wr_ctrl_val;
         s_d.ctrl.force_compare_strobe = 1'b0;
         if (wr_ctrl_val.force_compare_strobe
            && !is_pwm(wave_mode_t'({wr_ctrl_val.waveform_mode_high,
               wr_ctrl_val.waveform_mode_low}))) begin
            // No flag and no counter clear from a forced compare.
            s_d.compare_output = nonpwm_action(wr_ctrl_val.output_action,
               s_q.compare_output);
         end
      end

      // Counter write wins over counting and masks the next tick's match.
      if (wr_counter) begin
         s_d.counter_value = i_wb_dat[7:0];
         s_d.block_match = 1'b1;
      end

      // Compare write; immediate in non-PWM modes, else held in the buffer.
      if (wr_compare) begin
         s_d.compare_buf = i_wb_dat[7:0];
         if (!is_pwm(mode)) begin
            s_d.compare_act = i_wb_dat[7:0];
         end
      end

      if (wr_pin) begin
         s_d.pin_dir = i_wb_dat[BIT_PIN_DIR];
         s_d.port_data = i_wb_dat[BIT_PORT_DATA];
      end

      // Flag clears; a hardware set in the same cycle wins over the clear.
      if ((wr_flags && i_wb_dat[BIT_FLAG_OVF]) || i_overflow_vec_ack) begin
         s_d.overflow_flag = timer_tick & ((mode == MODE_PHASE) ? (s_q.dir_down & at_bottom)
            : at_max);
      end
      if ((wr_flags && i_wb_dat[BIT_FLAG_CMP]) || i_compare_vec_ack) begin
         s_d.compare_match_flag = match;
      end

      // Read data is captured together with ack so it is stable when ack shows.
      if (wb_req && !s_q.ack && !i_wb_we) begin
         case (i_wb_adr)
            OFS_CONTROL_A: s_d.rdat = {24'h000000, 1'b0, s_q.ctrl[6:0]};
            OFS_COUNTER: s_d.rdat = {24'h000000, s_q.counter_value};
            OFS_COMPARE: s_d.rdat = {24'h000000, s_q.compare_buf};
            OFS_FLAGS: s_d.rdat = {30'h00000000, s_q.compare_match_flag, s_q.overflow_flag};
            OFS_PIN_CFG: s_d.rdat = {30'h00000000, s_q.port_data, s_q.pin_dir};
            default: s_d.rdat = '0;
         endcase
      end
   end

   // State register.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.ctrl <= timer_control_a_t'(CONTROL_A_RESET);
      end else begin
         s_q <= s_d;
      end
   end

   // Pin mux: a connected compare output replaces the port data bit.
   assign o_wave_pin_o = (s_q.ctrl.output_action != 2'b00) ? s_q.compare_output
      : s_q.port_data;
   assign o_wave_pin_oe = s_q.pin_dir;
   assign o_compare_output = s_q.compare_output;
   assign o_overflow_flag = s_q.overflow_flag;
   assign o_compare_match_flag = s_q.compare_match_flag;
   assign o_wb_ack = s_q.ack;
   assign o_wb_dat = s_q.rdat;

endmodule // timer8_waveform_generator

// ### tb/timer8_assertions.sv
// Checker for the 8-bit timer: bus handshake, force strobe, flags and pin mux.
// Assumes it is bound to the top module and sees only the top module's ports.
`timescale 1ns/1ns
module timer8_assertions
   import timer8_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic i_overflow_vec_ack,
   input wire logic i_compare_vec_ack,
   input wire logic o_wave_pin_o,
   input wire logic o_wave_pin_oe,
   input wire logic o_compare_output,
   input wire logic o_overflow_flag,
   input wire logic o_compare_match_flag
);
   logic [7:0] ctl_q;
   logic dir_q;
   logic wr;
   // Shadows of control and pin direction, taken at the edge that ends a write.
   assign wr = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0];
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         ctl_q <= 8'h00;
         dir_q <= 1'b0;
      end else if (wr && i_wb_adr == OFS_CONTROL_A) begin
         ctl_q <= i_wb_dat[7:0];
      end else if (wr && i_wb_adr == OFS_PIN_CFG) begin
         dir_q <= i_wb_dat[BIT_PIN_DIR];
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // A forced compare in a stopped non-PWM mode, so no tick can mix in.
   sequence force_wr;
      wr && i_wb_adr == OFS_CONTROL_A && i_wb_dat[BIT_FORCE] && !i_wb_dat[6]
         && i_wb_dat[2:0] == 3'h0 && ctl_q[2:0] == 3'h0;
   endsequence
   ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("bus request not answered in one cycle");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   idle_data_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data not zero outside ack");
   force_reads_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == OFS_CONTROL_A
      |-> !o_wb_dat[BIT_FORCE]) else $error("force bit read as one");
   force_apply_a: assert property (force_wr |=> o_compare_output == ($past(i_wb_dat[5])
      ? $past(i_wb_dat[4]) : ($past(i_wb_dat[4]) ^ $past(o_compare_output))))
      else $error("forced compare gave wrong level");
   force_quiet_a: assert property (force_wr |=> !$rose(o_compare_match_flag)
      && !$rose(o_overflow_flag)) else $error("forced compare set a flag");
   stopped_still_a: assert property (ctl_q[2:0] == 3'h0 && !o_wb_ack && !i_overflow_vec_ack
      && !i_compare_vec_ack |=> $stable(o_compare_output) && $stable(o_overflow_flag)
      && $stable(o_compare_match_flag)) else $error("stopped timer changed state");
   ovf_vec_a: assert property (i_overflow_vec_ack && ctl_q[2:0] == 3'h0 |=> !o_overflow_flag)
      else $error("overflow flag not cleared by vector");
   cmp_vec_a: assert property (i_compare_vec_ack && ctl_q[2:0] == 3'h0
      |=> !o_compare_match_flag) else $error("compare flag not cleared by vector");
   pin_enable_a: assert property (o_wave_pin_oe == dir_q)
      else $error("pin enable differs from direction bit");
   pin_mux_a: assert property (ctl_q[5:4] != 2'h0 |-> o_wave_pin_o == o_compare_output)
      else $error("compare output does not own the pin");
endmodule // timer8_assertions

bind timer8_waveform_generator timer8_assertions timer8_assertions_inst (.i_core_clk, .i_rst,
   .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
   .i_overflow_vec_ack, .i_compare_vec_ack, .o_wave_pin_o, .o_wave_pin_oe, .o_compare_output,
   .o_overflow_flag, .o_compare_match_flag);

// ### tb/timer8_pin_model.sv
// Far-side model: drives the external count pin and carries the wave pin line.
// Assumes a pin level held three core cycles is slow enough to be sampled.
`timescale 1ns/1ns
module timer8_pin_model (
   input wire logic i_core_clk,
   input wire logic i_wave_pin_o,
   input wire logic i_wave_pin_oe,
   output logic o_external_count_pin,
   output logic o_wave_line
);
   // The line has a pull-up, so it reads high whenever the timer lets go.
   assign o_wave_line = i_wave_pin_oe ? i_wave_pin_o : 1'b1;
   initial o_external_count_pin = 1'b0;
   // Sends n whole pulses; each level stays put for three cycles so no edge is lost.
   task automatic send(input int n);
      repeat (2 * n) begin
         repeat (3) @(posedge i_core_clk);
         o_external_count_pin <= ~o_external_count_pin;
      end
   endtask
endmodule // timer8_pin_model

// ### tb/timer8_waveform_generator_bench.sv
// Self-checking bench for the 8-bit timer with waveform generator.
// Assumes the pin model on the far side and the checker bound to the top module.
`timescale 1ns/1ns
module timer8_waveform_generator_bench;
   import timer8_pkg::*;
   logic clk, rst, cyc, stb, we, ack, ovack, cmack, pin, wo, woe, cout, ovf, cmf, line, e;
   logic [7:0] adr, v;
   logic [31:0] wdat, rdat, q;
   logic [3:0] sel = 4'hf;
   int n_mismatch, checked, n, k, i, bad, act;
   int divs[4] = '{8, 64, 256, 1024};
   int ecs[3] = '{7, 6, 0};
   logic [7:0] pc[4] = '{8'h19, 8'h59, 8'h69, 8'h61};
   int pe[4];
   timer8_waveform_generator timer8_waveform_generator_inst (.i_core_clk(clk), .i_rst(rst),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_overflow_vec_ack(ovack),
      .i_compare_vec_ack(cmack), .i_external_count_pin(pin), .o_wave_pin_o(wo),
      .o_wave_pin_oe(woe), .o_compare_output(cout), .o_overflow_flag(ovf),
      .o_compare_match_flag(cmf));
   timer8_pin_model timer8_pin_model_inst (.i_core_clk(clk), .i_wave_pin_o(wo),
      .i_wave_pin_oe(woe), .o_external_count_pin(pin), .o_wave_line(line));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic bus cycle; the request stays put until ack is seen at an edge.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 20);
      if (t >= 20) check(32'h0, 32'h1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   // Cycles between two rises of the compare output; zero if fewer than two are seen in 2000 cycles.
   task automatic period(output int p);
      int s;
      logic last;
      s = -1;
      p = 0;
      last = cout;
      for (int c = 0; c < 2000 && p == 0; c++) begin
         @(posedge clk);
         if (cout && !last) begin
            if (s >= 0) p = c - s;
            s = c;
         end
         last = cout;
      end
   endtask
   // Level after a forced compare, and the steady phase-correct level at the extremes.
   function automatic logic fexp(input int a, input logic prev);
      return a[1] ? a[0] : (a[0] ^ prev);
   endfunction
   function automatic logic pcexp(input int a, input logic [7:0] c);
      return (c == 8'hff) ^ (a == 3);
   endfunction
   task automatic stop_test;
      $display("Counts: %0d comparisons, %0d mismatches", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // The whole run is near 25k cycles, so four times that means a hang.
   initial begin
      #(40 * 100000);
      n_mismatch++;
      stop_test;
   end
   initial begin
      {rst, cyc, stb, we, ovack, cmack, adr, wdat} = {1'b1, 45'h0};
      void'($urandom(84));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0);
      wr(OFS_CONTROL_A, 32'h7f);
      rdc(OFS_CONTROL_A, 32'h7f);
      wr(OFS_CONTROL_A, 32'h80);
      rdc(OFS_CONTROL_A, 32'h0);
      $display("Register test finished");
      wr(OFS_PIN_CFG, 32'h1);
      check(line, 1'b0);
      for (act = 1; act < 4; act++) begin
         e = fexp(act, cout);
         wr(OFS_CONTROL_A, 32'h80 | (act << 4));
         check(line, e);
      end
      rdc(OFS_FLAGS, 32'h0);
      $display("Force test finished");
      k = 2 + $urandom % 20;
      pe = '{2 * (k + 1), 512, 256, 510};
      for (i = 0; i < 4; i++) begin
         wr(OFS_CONTROL_A, 32'h0);
         wr(OFS_COUNTER, 32'h0);
         wr(OFS_COMPARE, k);
         wr(OFS_CONTROL_A, pc[i]);
         wr(OFS_FLAGS, 32'h3);
         period(n);
         period(n);
         check(n, pe[i]);
         rdc(OFS_FLAGS, (i > 0) ? 32'h3 : 32'h2);
      end
      $display("Period test finished");
      for (i = 0; i < 4; i++) begin
         v = i[0] ? 8'hff : 8'h00;
         act = 2 + i[1];
         wr(OFS_COMPARE, v);
         wr(OFS_CONTROL_A, 32'h41 | (act << 4));
         // A new compare loads only at MAX and the level settles at BOTTOM, up to 765 ticks.
         repeat (800) @(posedge clk);
         bad = 0;
         repeat (520) begin
            @(posedge clk);
            if (cout !== pcexp(act, v)) bad++;
         end
         check(bad, 0);
      end
      $display("Extreme compare test finished");
      wr(OFS_CONTROL_A, 32'h0);
      wr(OFS_COMPARE, 32'h0);
      wr(OFS_COUNTER, 32'hf0);
      wr(OFS_CONTROL_A, 32'h1);
      repeat (40) @(posedge clk);
      wr(OFS_FLAGS, 32'h2);
      wr(OFS_COUNTER, 32'h0);
      repeat (3) @(posedge clk);
      rdc(OFS_FLAGS, 32'h1);
      // Let the counter wrap so both flags are set before the vector clears.
      repeat (260) @(posedge clk);
      wr(OFS_CONTROL_A, 32'h0);
      check({ovf, cmf}, 2'b11);
      ovack <= 1'b1;
      cmack <= 1'b1;
      @(posedge clk);
      ovack <= 1'b0;
      cmack <= 1'b0;
      @(posedge clk);
      check({ovf, cmf}, 2'b00);
      $display("Flag test finished");
      for (i = 0; i < 4; i++) begin
         wr(OFS_CONTROL_A, 32'h0);
         wr(OFS_COUNTER, 32'h0);
         wr(OFS_CONTROL_A, 2 + i);
         repeat (8 * divs[i]) @(posedge clk);
         wb(1'b0, OFS_COUNTER, 32'h0);
         check(q >= 8 && q <= 9, 1'b1);
      end
      for (i = 0; i < 3; i++) begin
         n = 1 + $urandom % 10;
         wr(OFS_CONTROL_A, 32'h0);
         wr(OFS_COUNTER, 32'h0);
         wr(OFS_CONTROL_A, ecs[i]);
         timer8_pin_model_inst.send(n);
         repeat (6) @(posedge clk);
         rdc(OFS_COUNTER, (i < 2) ? n : 0);
      end
      $display("Clock source test finished");
      stop_test;
   end
endmodule // timer8_waveform_generator_bench
